/* acg_top.sv */
// Acquire clock generator: prescaler, range mux, decade divider, output select,
// intensify gating and delay-mode encoding, with AHB-Lite registers.
// Assumes hclk at 40 MHz; pins ext_clock_in, display_b_in, delay_gate_in are asynchronous.
module acg_top
	import acg_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic ext_clock_in,
	input wire logic display_b_in,
	input wire logic delay_gate_in,
	output logic acquire_clock,
	output logic osc_enable,
	output logic x1_strobe_n,
	output logic x10_strobe_n,
	output logic intensify,
	output logic acquire_stop_gate,
	output logic [1:0] delay_mode
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	function automatic logic [3:0] dec_next(input logic [3:0] v);
		dec_next = (v == DEC_LAST) ? 4'h0 : v + 4'h1;
	endfunction
	logic [4:0] sweep_reg;
	logic magnifier_setting_reg;
	logic [1:0] mode_sw_reg;
	logic comp_b_reg;
	logic wr_pend_reg;
	logic [31:0] wr_addr_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] rd_word;
	logic addr_ok;
	// Bus: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign addr_ok = hsel & htrans[1] & hready;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= CTRL_OFS;
		end else begin
			// Only whole-word writes are stored; narrower ones are ignored
			wr_pend_reg <= addr_ok & hwrite & (hsize == HSIZE_WORD);
			wr_addr_reg <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sweep_reg <= SWEEP_RST;
			magnifier_setting_reg <= 1'b0;
			mode_sw_reg <= MODE_RST;
			comp_b_reg <= 1'b0;
		end else if (wr_pend_reg && wr_addr_reg == CTRL_OFS) begin
			sweep_reg <= hwdata[CTRL_SWEEP_LSB +: 5];
			magnifier_setting_reg <= hwdata[CTRL_MAGNIFIER_BIT];
			mode_sw_reg <= hwdata[CTRL_MODE_LSB +: 2];
			comp_b_reg <= hwdata[CTRL_COMP_BIT];
		end
	end
	// Oscillator reference made as a tick stream on hclk
	logic osc_en_c;
	logic ref_tick;
	logic [7:0] ref_sum;
	logic [7:0] ref_wrap;
	logic [6:0] ref_acc_reg;
	// Stops when the sweep is too fast or the external line is pressed
	assign osc_en_c = (sweep_reg <= X1_LAST) & mode_sw_reg[0];
	assign ref_sum = {1'b0, ref_acc_reg} + {1'b0, REF_STEP};
	assign ref_wrap = ref_sum - {1'b0, REF_MOD};
	assign ref_tick = osc_en_c & (ref_sum >= {1'b0, REF_MOD});
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_acc_reg <= REF_ACC_RST;
		end else if (!osc_en_c) begin
			ref_acc_reg <= REF_ACC_RST;
		end else begin
			ref_acc_reg <= ref_tick ? ref_wrap[6:0] : ref_sum[6:0];
		end
	end
	// Prescaler: every stage is an enable on the one clock, no derived clocks
	logic half_reg;
	logic [3:0] ten_reg;
	logic [1:0] quad_reg;
	logic [4:0] pre_lvl_reg;
	logic p10_tick;
	logic p5_tick;
	logic p2048_tick;
	logic p1024_tick;
	logic p512_tick;
	assign p10_tick = ref_tick & half_reg;
	assign p5_tick = p10_tick & ten_reg[0];
	assign p2048_tick = p10_tick & (ten_reg == FIFTH_A | ten_reg == FIFTH_B);
	assign p1024_tick = p2048_tick & quad_reg[0];
	assign p512_tick = p2048_tick & (quad_reg == QUARTER_LAST);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			half_reg <= 1'b0;
			ten_reg <= 4'h0;
			quad_reg <= 2'h0;
		end else begin
			if (ref_tick) begin
				half_reg <= ~half_reg;
			end
			if (p10_tick) begin
				ten_reg <= dec_next(ten_reg);
			end
			if (p2048_tick) begin
				quad_reg <= quad_reg + 2'h1;
			end
		end
	end
	// Square-wave levels of each stage, visible in the status word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_lvl_reg <= 5'h00;
		end else begin
			pre_lvl_reg <= pre_lvl_reg ^ {p512_tick, p1024_tick, p2048_tick, p5_tick, p10_tick};
		end
	end
	// Sweep decode: magnifier moves the rate up by one decade
	logic [4:0] eff_idx;
	logic [4:0] eff_quot;
	logic [4:0] eff_rem;
	logic [2:0] dec_code;
	logic x1_en;
	logic x10_en;
	acg_range_type range_sel;
	logic range_tick;
	assign x1_en = ~magnifier_setting_reg & (sweep_reg <= X1_LAST);
	assign x10_en = magnifier_setting_reg & (sweep_reg <= X10_LAST);
	assign eff_idx = sweep_reg + (magnifier_setting_reg ? MAGNIFY_STEP : 5'h00);
	assign eff_quot = eff_idx / STEP_DIV;
	assign eff_rem = eff_idx % STEP_DIV;
	// 5-2-1 pattern maps to 2.048, 5.12, 10.24 MHz taps
	always_comb begin
		if (eff_idx == REF_DIRECT) begin
			range_sel = RNG_20M48;
			dec_code = 3'h0;
		end else begin
			unique case (eff_rem[1:0])
				2'h0: range_sel = RNG_2M048;
				2'h1: range_sel = RNG_5M12;
				default: range_sel = RNG_10M24;
			endcase
			dec_code = DEC_TOP - eff_quot[2:0];
		end
	end

	// Range multiplexer, gated by whichever strobe is active
	always_comb begin
		unique case (range_sel)
			RNG_20M48: range_tick = ref_tick;
			RNG_10M24: range_tick = p10_tick;
			RNG_5M12: range_tick = p5_tick;
			RNG_2M048: range_tick = p2048_tick;
		endcase
		range_tick = range_tick & (x1_en | x10_en);
	end

	// Decade divider chain; taps 0..5 are divide by 1 to 100k
	logic [3:0] dec_reg [5];
	logic [7:0] dec_tick;
	logic int_tick;
	logic [6:0] hund_reg;
	logic k_tick;
	always_comb begin
		dec_tick = 8'h00;
		dec_tick[0] = range_tick;
		for (int k = 0; k < 5; k++) begin
			dec_tick[k + 1] = dec_tick[k] & (dec_reg[k] == DEC_LAST);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int k = 0; k < 5; k++) begin
				dec_reg[k] <= 4'h0;
			end
		end else begin
			for (int k = 0; k < 5; k++) begin
				if (dec_tick[k]) begin
					dec_reg[k] <= dec_next(dec_reg[k]);
				end
			end
		end
	end

	assign int_tick = dec_tick[dec_code];
	// Thousandth clock counts the divide-by-ten tap, not the selected tap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hund_reg <= 7'h00;
		end else if (dec_tick[1]) begin
			hund_reg <= (hund_reg == HUNDRED_LAST) ? 7'h00 : hund_reg + 7'h01;
		end
	end

	assign k_tick = dec_tick[1] & (hund_reg == HUNDRED_LAST);
	// Pin synchronisers: {delay gate, display B, external clock}
	logic [2:0] pin_s1_reg;
	logic [2:0] pin_s2_reg;
	logic [2:0] pin_s3_reg;
	logic [2:0] pin_lvl_reg;
	logic ext_tick;
	logic disp_b;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_reg <= 3'h0;
			pin_s2_reg <= 3'h0;
			pin_s3_reg <= 3'h0;
			pin_lvl_reg <= 3'h0;
		end else begin
			pin_s1_reg <= {delay_gate_in, display_b_in, ext_clock_in};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			for (int k = 0; k < 3; k++) begin
				if (pin_s2_reg[k] == pin_s3_reg[k]) begin
					pin_lvl_reg[k] <= pin_s2_reg[k];
				end
			end
		end
	end

	// Inverted copy rises when the agreed input falls
	assign ext_tick = (pin_s2_reg[0] == pin_s3_reg[0]) & ~pin_s2_reg[0] & pin_lvl_reg[0];
	assign disp_b = pin_lvl_reg[1];

	// Output selector and delay-mode encoding
	acg_mode_type mode;
	acg_delay_type dly_c;
	logic sel_tick;
	assign mode = acg_mode_type'(mode_sw_reg);
	always_comb begin
		unique case (mode)
			MODE_INT: begin
				sel_tick = int_tick;
				dly_c = DLY_INDEP;
			end
			MODE_DIV1K: begin
				sel_tick = k_tick;
				dly_c = DLY_START;
			end
			MODE_EXT: begin
				sel_tick = ext_tick;
				dly_c = DLY_TRIG;
			end
			MODE_NONE: begin
				// Both buttons pressed is not a panel state; stay quiet
				sel_tick = 1'b0;
				dly_c = DLY_INDEP;
			end
		endcase
	end
	logic [15:0] acq_cnt_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acquire_clock <= 1'b0;
			osc_enable <= 1'b0;
			x1_strobe_n <= 1'b1;
			x10_strobe_n <= 1'b1;
			delay_mode <= DLY_INDEP;
		end else begin
			acquire_clock <= sel_tick;
			osc_enable <= osc_en_c;
			x1_strobe_n <= ~x1_en;
			x10_strobe_n <= ~x10_en;
			delay_mode <= dly_c;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			intensify <= 1'b0;
			acquire_stop_gate <= 1'b0;
		end else begin
			intensify <= comp_b_reg & disp_b & (sweep_reg <= INTENS_LAST);
			acquire_stop_gate <= comp_b_reg & pin_lvl_reg[2];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acq_cnt_reg <= CNT_RST;
		end else if (sel_tick) begin
			acq_cnt_reg <= acq_cnt_reg + 16'h0001;
		end
	end

	// Read data is sampled in the address phase; unmapped reads give zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (haddr == CTRL_OFS) begin
			rd_word[CTRL_SWEEP_LSB +: 5] = sweep_reg;
			rd_word[CTRL_MAGNIFIER_BIT] = magnifier_setting_reg;
			rd_word[CTRL_MODE_LSB +: 2] = mode_sw_reg;
			rd_word[CTRL_COMP_BIT] = comp_b_reg;
		end else if (haddr == STATUS_OFS) begin
			rd_word[ST_OSC] = osc_enable;
			rd_word[ST_X1N] = x1_strobe_n;
			rd_word[ST_X10N] = x10_strobe_n;
			rd_word[ST_DLY_LSB +: 2] = delay_mode;
			rd_word[ST_INT] = intensify;
			rd_word[ST_STOP] = acquire_stop_gate;
			rd_word[ST_EXT] = ~pin_lvl_reg[0];
			rd_word[ST_PRE_LSB +: 5] = pre_lvl_reg;
		end else if (haddr == COUNT_OFS) begin
			rd_word[15:0] = acq_cnt_reg;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			hrdata_reg <= rd_word;
		end
	end
	chk_half_ref: assert property (p10_tick |-> ref_tick)
		else $error("10.24 MHz tick without reference tick");
	chk_fifth_tap: assert property (p2048_tick |-> p10_tick ##1 !p2048_tick)
		else $error("2.048 MHz tick not on a 10.24 MHz tick");
	chk_quarter_tap: assert property (p512_tick |-> p1024_tick && p2048_tick)
		else $error("512 kHz tick off the 1.024 MHz tick");
	chk_ext_stop: assert property (!mode_sw_reg[0] |-> !ref_tick ##1 !osc_enable)
		else $error("Oscillator enabled in external mode");
	chk_x1_window: assert property ((!magnifier_setting_reg && sweep_reg <= X1_LAST)
		|=> (!x1_strobe_n && x10_strobe_n))
		else $error("Unity strobe wrong inside its range");
	chk_x10_window: assert property ((magnifier_setting_reg && sweep_reg <= X10_LAST)
		|=> (x1_strobe_n && !x10_strobe_n))
		else $error("Times-ten strobe wrong inside its range");
	chk_range_idle: assert property ((sweep_reg > X1_LAST) |-> !range_tick ##1
		(x1_strobe_n && x10_strobe_n))
		else $error("Clock or strobe active above range");
	chk_div_1000: assert property (k_tick |-> dec_tick[1] && hund_reg == HUNDRED_LAST)
		else $error("Thousandth tick off the ten tap");
	chk_output_pick: assert property ((mode == MODE_DIV1K) |=>
		(acquire_clock == $past(k_tick)))
		else $error("Thousandth mode did not pass its clock");
	chk_ext_invert: assert property (ext_tick |=> !pin_lvl_reg[0] ##1 !ext_tick)
		else $error("External tick not on inverted rise");
	chk_intensify_gate: assert property (intensify |->
		($past(comp_b_reg) && $past(disp_b) && $past(sweep_reg) <= INTENS_LAST))
		else $error("Intensify without its conditions");
	chk_stop_gate_a: assert property (!comp_b_reg |=> (!acquire_stop_gate && !intensify))
		else $error("First compartment produced gate or intensify");
	chk_delay_code: assert property ((mode == MODE_EXT) |=> delay_mode == DLY_TRIG)
		else $error("External mode delay code wrong");
endmodule // acg_top

/* acg_pkg.sv */
// Constants, field layout and types for the acquire clock generator.
// Assumes one 40 MHz bus clock, one AHB-Lite master and static panel settings.
package acg_pkg;
	// Reference rate is made by a fractional step on the bus clock
	localparam int HCLK_KHZ = 40000;
	localparam int REF_KHZ = 20480;
	localparam int RATIO_GCD = 320;
	localparam logic [6:0] REF_STEP = 7'(REF_KHZ / RATIO_GCD);
	localparam logic [6:0] REF_MOD = 7'(HCLK_KHZ / RATIO_GCD);
	localparam logic [6:0] REF_ACC_RST = 7'h00;
	localparam logic [3:0] DEC_LAST = 4'h9;
	localparam logic [3:0] FIFTH_A = 4'h4;
	localparam logic [3:0] FIFTH_B = 4'h9;
	localparam logic [1:0] QUARTER_LAST = 2'h3;
	localparam logic [6:0] HUNDRED_LAST = 7'h63;
	// Sweep index 0 is 5 s/div, each step one 1-2-5 setting faster
	localparam logic [4:0] SWEEP_RST = 5'h00;
	localparam logic [4:0] X1_LAST = 5'h11;
	localparam logic [4:0] X10_LAST = 5'h0F;
	localparam logic [4:0] INTENS_LAST = 5'h10;
	localparam logic [4:0] MAGNIFY_STEP = 5'h03;
	localparam logic [4:0] STEP_DIV = 5'h03;
	localparam logic [4:0] REF_DIRECT = 5'h12;
	localparam logic [2:0] DEC_TOP = 3'h5;
	localparam logic [15:0] CNT_RST = 16'h0000;
	// Register map
	localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
	localparam logic [31:0] STATUS_OFS = 32'h0000_0004;
	localparam logic [31:0] COUNT_OFS = 32'h0000_0008;
	localparam int CTRL_SWEEP_LSB = 0;
	localparam int CTRL_MAGNIFIER_BIT = 8;
	localparam int CTRL_MODE_LSB = 9;
	localparam int CTRL_COMP_BIT = 12;
	localparam int ST_OSC = 0;
	localparam int ST_X1N = 1;
	localparam int ST_X10N = 2;
	localparam int ST_DLY_LSB = 3;
	localparam int ST_INT = 5;
	localparam int ST_STOP = 6;
	localparam int ST_EXT = 7;
	localparam int ST_PRE_LSB = 8;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	typedef enum logic [1:0] {
		RNG_20M48 = 2'h0,
		RNG_10M24 = 2'h1,
		RNG_5M12 = 2'h2,
		RNG_2M048 = 2'h3
	} acg_range_type;
	// Raw mode lines {high, low}, each low while its button is pressed
	typedef enum logic [1:0] {
		MODE_NONE = 2'h0,
		MODE_INT = 2'h1,
		MODE_EXT = 2'h2,
		MODE_DIV1K = 2'h3
	} acg_mode_type;
	localparam logic [1:0] MODE_RST = 2'h1;
	// Delay mode line: 0 V, +5.0 V, +3.6 V
	typedef enum logic [1:0] {
		DLY_INDEP = 2'h0,
		DLY_START = 2'h1,
		DLY_TRIG = 2'h2
	} acg_delay_type;
endpackage

/* acg_mainframe_model.sv */
// Mainframe side model: drives the external clock pin, display line and delay gate.
// Assumes the bench steers it through level and run controls sampled on hclk.
module acg_mainframe_model (
	input wire logic hclk,
	input wire logic ext_run,
	input wire logic ext_level,
	input wire logic [7:0] ext_half,
	input wire logic disp_level,
	input wire logic gate_level,
	output logic ext_clock_in,
	output logic display_b_in,
	output logic delay_gate_in
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt = 0;
	// Display and gate lines follow the bench one edge late, as a real mainframe lags
	always @(posedge hclk) begin
		display_b_in <= disp_level;
		delay_gate_in <= gate_level;
		if (!ext_run) begin
			ext_clock_in <= ext_level;
			cnt <= 0;
		end else if (cnt + 1 >= int'(ext_half)) begin
			ext_clock_in <= ~ext_clock_in;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule // acg_mainframe_model

/* tb_acquire_clock_generator.sv */
// Self-checking bench for the acquire clock generator with a mainframe model.
// Assumes a 40 MHz bus clock and the one AHB-Lite slave answering OKAY.
module tb_acquire_clock_generator;
	import acg_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int LIMIT = 80000;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = HSIZE_WORD;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic hreadyout, hresp, ext_clock_in, display_b_in, delay_gate_in, acquire_clock;
	logic osc_enable, x1_strobe_n, x10_strobe_n, intensify, acquire_stop_gate;
	logic [1:0] delay_mode, mode;
	logic ext_run = 1'b0, ext_level = 1'b1, disp_level = 1'b0, gate_level = 1'b0, comp, d, g;
	int n_errors = 0, total_checks = 0, cycles = 0, pulses = 0, p0;
	initial begin
		forever #12.5 hclk = ~hclk;
	end
	acg_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_clock_in(ext_clock_in),
		.display_b_in(display_b_in), .delay_gate_in(delay_gate_in),
		.acquire_clock(acquire_clock), .osc_enable(osc_enable), .x1_strobe_n(x1_strobe_n),
		.x10_strobe_n(x10_strobe_n), .intensify(intensify),
		.acquire_stop_gate(acquire_stop_gate), .delay_mode(delay_mode));
	acg_mainframe_model mf (.hclk(hclk), .ext_run(ext_run), .ext_level(ext_level),
		.ext_half(8'h0A), .disp_level(disp_level), .gate_level(gate_level),
		.ext_clock_in(ext_clock_in), .display_b_in(display_b_in), .delay_gate_in(delay_gate_in));
	always @(posedge hclk) begin
		cycles++;
		if (acquire_clock === 1'b1)
			pulses++;
		if (cycles == LIMIT) begin
			n_errors++;
			give_verdict();
		end
	end
	task give_verdict();
		$display("Checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Pulse counts jitter by one hclk at the window ends, so allow a pulse and a half
	task cmp_count(input string name, input int got, input real exp);
		total_checks++;
		if (real'(got) > exp + 1.5 || real'(got) < exp - 1.5) begin
			n_errors++;
			$display("Error %s expected %0.2f seen %0d", name, exp, got);
		end
	endtask
	task idle(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// Entered just after a rising edge; leaves just after the data-phase edge
	task bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= addr;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	function automatic logic [31:0] ctrl_word(logic [4:0] i, logic m, logic [1:0] md, logic c);
		return (32'(i) << CTRL_SWEEP_LSB) | (32'(m) << CTRL_MAGNIFIER_BIT) |
			(32'(md) << CTRL_MODE_LSB) | (32'(c) << CTRL_COMP_BIT);
	endfunction
	task meas(input logic [4:0] i, input logic m, input logic [1:0] md, input int n, input real f);
		bus(1'b1, CTRL_OFS, ctrl_word(i, m, md, 1'b0));
		idle(50);
		p0 = pulses;
		idle(n);
		cmp_count("acquire_clock count", pulses - p0, f * real'(n) * 25.0e-9);
	endtask
	initial begin
		void'($urandom(32'hEE6D));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, CTRL_OFS, 32'h0);
		check("ctrl reset", 32'h0000_0200, rd & 32'h0000_171F);
		check("osc reset", 32'h1, 32'(osc_enable));
		for (int m = 0; m < 2; m++) begin
			for (int i = 0; i < 27; i++) begin
				mode = 2'($urandom_range(3));
				comp = 1'($urandom_range(1));
				d = 1'($urandom_range(1));
				g = 1'($urandom_range(1));
				disp_level <= d;
				gate_level <= g;
				bus(1'b1, CTRL_OFS, ctrl_word(5'(i), 1'(m), mode, comp));
				idle(8);
				@(negedge hclk);
				check("osc_enable", 32'(i <= 17 && mode[0]), 32'(osc_enable));
				check("x1_strobe_n", 32'(!(m == 0 && i <= 17)), 32'(x1_strobe_n));
				check("x10_strobe_n", 32'(!(m == 1 && i <= 15)), 32'(x10_strobe_n));
				check("intensify", 32'(comp && d && i < 17), 32'(intensify));
				check("stop gate", 32'(comp && g), 32'(acquire_stop_gate));
				check("delay_mode", (mode == MODE_EXT) ? 32'h2 : 32'(mode == MODE_DIV1K),
					32'(delay_mode));
				@(posedge hclk);
				bus(1'b0, CTRL_OFS, 32'h0);
				check("ctrl", ctrl_word(5'(i), 1'(m), mode, comp), rd & 32'h0000_171F);
			end
		end
		bus(1'b0, 32'h0000_000C, 32'h0);
		check("unmapped", 32'h0, rd);
		check("hresp", 32'h0, 32'(hresp));
		bus(1'b1, CTRL_OFS, ctrl_word(5'h00, 1'b0, MODE_EXT, 1'b0));
		ext_level <= 1'b0;
		idle(8);
		bus(1'b0, STATUS_OFS, 32'h0);
		check("ext inverted", 32'h1, 32'(rd[ST_EXT]));
		ext_run <= 1'b1;
		p0 = pulses;
		idle(400);
		cmp_count("ext pulses", pulses - p0, 20.0);
		ext_run <= 1'b0;
		meas(5'h0F, 1'b0, MODE_INT, 2000, 2.048e6);
		meas(5'h0F, 1'b1, MODE_INT, 2000, 20.48e6);
		meas(5'h08, 1'b1, MODE_INT, 10000, 102.4e3);
		meas(5'h07, 1'b1, MODE_INT, 10000, 51.2e3);
		meas(5'h08, 1'b0, MODE_INT, 20000, 10.24e3);
		meas(5'h0F, 1'b1, MODE_DIV1K, 20000, 20.48e3);
		meas(5'h10, 1'b1, MODE_INT, 2000, 0.0);
		meas(5'h12, 1'b0, MODE_INT, 2000, 0.0);
		// Narrow writes must leave the control word alone
		hsize <= 3'h0;
		bus(1'b1, CTRL_OFS, ctrl_word(5'h03, 1'b1, MODE_DIV1K, 1'b1));
		hsize <= HSIZE_WORD;
		bus(1'b0, CTRL_OFS, 32'h0);
		check("byte write", ctrl_word(5'h12, 1'b0, MODE_INT, 1'b0),
			rd & 32'h0000_171F);
		// Clock is stopped here, so the pulse counter must match the bench tally
		bus(1'b0, COUNT_OFS, 32'h0);
		check("count", {16'h0000, 16'(pulses)}, rd);
		give_verdict();
	end
endmodule // tb_acquire_clock_generator
